// ### hdl/ssx_pkg.sv
package ssx_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam logic [11:0] SSX_OFF_CMD    = 12'h000;
    localparam logic [11:0] SSX_OFF_OPER   = 12'h004;
    localparam logic [11:0] SSX_OFF_ACC    = 12'h008;
    localparam logic [11:0] SSX_OFF_RESULT = 12'h00c;
    localparam logic [11:0] SSX_OFF_STATUS = 12'h010;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int SSX_CMD_OP_LSB    = 0;
    localparam int SSX_CMD_TGT_BIT   = 4;
    localparam int SSX_OPER_IMM_LSB  = 0;
    localparam int SSX_OPER_IDX_LSB  = 8;
    localparam int SSX_ST_CARRY_BIT  = 0;
    localparam int SSX_ST_NIB_BIT    = 1;
    localparam int SSX_ST_ZERO_BIT   = 2;
    localparam int SSX_RES_TGT_BIT   = 8;
    localparam int SSX_RES_IDX_LSB   = 16;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]  SSX_ACC_RST  = 8'h00;
    localparam logic [2:0]  SSX_FLAG_RST = 3'h0;
    localparam logic [31:0] SSX_ZERO32   = 32'h0000_0000;

    // ----------------------------------------------------------------
    // operation codes
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        SSX_OP_NONE          = 4'h0,
        SSX_OP_SUB_ACC_IMM   = 4'h1,
        SSX_OP_SUB_ACC_REG   = 4'h2,
        SSX_OP_NIBBLE_XCHG   = 4'h3,
        SSX_OP_XOR_ACC_IMM   = 4'h4,
        SSX_OP_XOR_ACC_REG   = 4'h5
    } ssx_op_t;

    // file register operand from the register file
    typedef struct packed {
        logic [6:0] idx;
        logic [7:0] data;
    } ssx_freg_t;

    // write-back toward the register file
    typedef struct packed {
        logic       valid;
        logic [6:0] idx;
        logic [7:0] data;
    } ssx_wb_t;

    // status flags
    typedef struct packed {
        logic zero;
        logic nibble_borrow_inverse;
        logic carry;
    } ssx_flags_t;

endpackage

// ### hdl/ssx_alu.sv
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
// Operation
// (RULE_01) immediate minus accumulator into accumulator
// (RULE_02) subtract-immediate borrow and nibble-borrow flags
// (RULE_03) register minus accumulator, target select destination
// (RULE_04) subtract-register updates carry, nibble, zero
// (RULE_05) swap register nibbles, no flag change
// (RULE_06) xor accumulator with immediate, zero only
// (RULE_07) xor accumulator with register, target select
// (RULE_08) zero flag set when result zero
module ssx_alu
    import ssx_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // register file side
    input  wire ssx_freg_t   freg_in,
    output ssx_wb_t          freg_wb,
    output logic [6:0]       freg_idx
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0]  acc_reg,    acc_next;
    ssx_flags_t  flags_reg,  flags_next;
    logic [7:0]  imm_reg,    imm_next;
    logic [6:0]  idx_reg,    idx_next;
    logic [7:0]  result_reg, result_next;
    logic        tgt_reg,    tgt_next;
    ssx_wb_t     wb_reg,     wb_next;
    logic [31:0] rdata_reg,  rdata_next;
    logic        ready_reg,  ready_next;
    logic        err_reg,    err_next;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // minuend minus accumulator; carry and nibble carry mean no borrow
    function automatic logic [9:0] ssx_sub(input logic [7:0] m, input logic [7:0] a);
        logic [8:0] diff;
        logic       nib;
        diff = {1'b0, m} - {1'b0, a};
        nib  = (a[3:0] <= m[3:0]);
        return {nib, ~diff[8], diff[7:0]};
    endfunction

    function automatic logic [7:0] ssx_merge(input logic [7:0] old, input logic [31:0] wd, input logic en);
        return en ? wd[7:0] : old;
    endfunction

    wire logic access = psel & penable & ~ready_reg;
    wire logic wr_acc = access & pwrite;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [9:0] sub;
        logic [7:0] res;
        ssx_op_t    op;
        sub         = 10'h000;
        res         = 8'h00;
        op          = SSX_OP_NONE;
        acc_next    = acc_reg;
        flags_next  = flags_reg;
        imm_next    = imm_reg;
        idx_next    = idx_reg;
        result_next = result_reg;
        tgt_next    = tgt_reg;
        wb_next     = '{valid: 1'b0, idx: wb_reg.idx, data: wb_reg.data};
        rdata_next  = SSX_ZERO32;
        ready_next  = access;
        err_next    = 1'b0;
        if (access) begin
            if (paddr == SSX_OFF_CMD) begin
                if (pwrite && pstrb[0]) begin
                    op  = ssx_op_t'(pwdata[SSX_CMD_OP_LSB +: 4]);
                    case (op)
                        SSX_OP_SUB_ACC_IMM: begin
                            // (RULE_01) immediate minus accumulator
                            sub = ssx_sub(imm_reg, acc_reg);
                            res = sub[7:0];
                            acc_next = res;
                            tgt_next = 1'b0;
                            // (RULE_02) borrow flags
                            flags_next.carry = sub[8];
                            flags_next.nibble_borrow_inverse = sub[9];
                            // (RULE_08) zero flag
                            flags_next.zero = (res == 8'h00);
                        end
                        SSX_OP_SUB_ACC_REG: begin
                            // (RULE_03) register minus accumulator
                            sub = ssx_sub(freg_in.data, acc_reg);
                            res = sub[7:0];
                            // (RULE_04) carry, nibble and zero
                            flags_next.carry = sub[8];
                            flags_next.nibble_borrow_inverse = sub[9];
                            flags_next.zero = (res == 8'h00);
                        end
                        SSX_OP_NIBBLE_XCHG: begin
                            // (RULE_05) nibble exchange, flags kept
                            res = {freg_in.data[3:0], freg_in.data[7:4]};
                        end
                        SSX_OP_XOR_ACC_IMM: begin
                            // (RULE_06) xor with immediate
                            res = acc_reg ^ imm_reg;
                            acc_next = res;
                            tgt_next = 1'b0;
                            flags_next.zero = (res == 8'h00);
                        end
                        SSX_OP_XOR_ACC_REG: begin
                            // (RULE_07) xor with register
                            res = acc_reg ^ freg_in.data;
                            // (RULE_08) zero flag
                            flags_next.zero = (res == 8'h00);
                        end
                        default: begin
                            res = result_reg;
                        end
                    endcase
                    result_next = res;
                    // target select picks accumulator or file register
                    // only valid register ops record the target, so a bad code changes no state
                    if (op == SSX_OP_SUB_ACC_REG || op == SSX_OP_NIBBLE_XCHG || op == SSX_OP_XOR_ACC_REG) begin
                        tgt_next = pwdata[SSX_CMD_TGT_BIT];
                        if (pwdata[SSX_CMD_TGT_BIT]) begin
                            wb_next = '{valid: 1'b1, idx: idx_reg, data: res};
                        end else begin
                            acc_next = res;
                        end
                    end
                    if (op == SSX_OP_NONE || op > SSX_OP_XOR_ACC_REG) begin
                        err_next = 1'b1;
                    end
                end
            end else if (paddr == SSX_OFF_OPER) begin
                if (pwrite) begin
                    imm_next = ssx_merge(imm_reg, pwdata, pstrb[0]);
                    if (pstrb[1]) begin
                        idx_next = pwdata[SSX_OPER_IDX_LSB +: 7];
                    end
                end else begin
                    rdata_next = {17'h0, idx_reg, imm_reg};
                end
            end else if (paddr == SSX_OFF_ACC) begin
                if (pwrite) begin
                    acc_next = ssx_merge(acc_reg, pwdata, pstrb[0]);
                end else begin
                    rdata_next = {24'h000000, acc_reg};
                end
            end else if (paddr == SSX_OFF_RESULT) begin
                if (!pwrite) begin
                    rdata_next = {9'h0, wb_reg.idx, 7'h0, tgt_reg, result_reg};
                end
            end else if (paddr == SSX_OFF_STATUS) begin
                if (pwrite) begin
                    if (pstrb[0]) begin
                        flags_next = pwdata[2:0];
                    end
                end else begin
                    rdata_next = {29'h0, flags_reg};
                end
            end else begin
                err_next = 1'b1;
            end
        end
        if (!wr_acc) begin
            wb_next.valid = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg    <= SSX_ACC_RST;
            flags_reg  <= SSX_FLAG_RST;
            imm_reg    <= 8'h00;
            idx_reg    <= 7'h0;
            result_reg <= 8'h00;
            tgt_reg    <= 1'b0;
            wb_reg     <= '0;
            rdata_reg  <= SSX_ZERO32;
            ready_reg  <= 1'b0;
            err_reg    <= 1'b0;
        end else begin
            acc_reg    <= acc_next;
            flags_reg  <= flags_next;
            imm_reg    <= imm_next;
            idx_reg    <= idx_next;
            result_reg <= result_next;
            tgt_reg    <= tgt_next;
            wb_reg     <= wb_next;
            rdata_reg  <= rdata_next;
            ready_reg  <= ready_next;
            err_reg    <= err_next;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // index held in a flop so the register file can present data ahead of the command
    assign freg_idx = idx_reg;
    assign freg_wb  = wb_reg;
    assign prdata   = rdata_reg;
    assign pready   = ready_reg;
    assign pslverr  = err_reg;

endmodule

// ### tb/ssx_alu_properties.sv
`timescale 1ns/1ps
module ssx_alu_properties
    import ssx_pkg::*;
(
    // apb side
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // register file side
    input wire ssx_freg_t   freg_in,
    input wire ssx_wb_t     freg_wb,
    input wire logic [6:0]  freg_idx
);
    logic       cmd_wr;
    logic [3:0] op;
    assign op = pwdata[3:0];
    assign cmd_wr = psel && penable && !pready && pwrite && paddr == 12'h000 && pstrb[0];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence swap_done;
        cmd_wr && op == 4'h3 && pwdata[4] ##1 pready;
    endsequence
    sequence reg_tgt_done;
        cmd_wr && pwdata[4] && (op == 4'h2 || op == 4'h5) ##1 pready;
    endsequence
    a_ready_next: assert property (psel && penable && !pready |=> pready) else $error("pready late");
    a_ready_once: assert property (pready |=> !pready) else $error("pready too long");
    a_err_paired: assert property (pslverr |-> pready) else $error("pslverr without pready");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle");
    a_wb_index: assert property (freg_wb.valid |-> freg_wb.idx == $past(freg_idx))
        else $error("write-back index wrong");
    a_tgt_writeback: assert property (reg_tgt_done |-> freg_wb.valid && !pslverr)
        else $error("write-back missing");
    a_acc_quiet: assert property (cmd_wr && !pwdata[4] |=> !freg_wb.valid)
        else $error("write-back with target 0");
    a_swap_route: assert property (swap_done |-> freg_wb.data == {$past(freg_in.data[3:0]),
        $past(freg_in.data[7:4])}) else $error("nibbles not exchanged");
    a_bad_op: assert property (cmd_wr && (op == 4'h0 || op > 4'h5) |=> pslverr && !freg_wb.valid)
        else $error("bad op accepted");
endmodule
bind ssx_alu ssx_alu_properties i_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .freg_in(freg_in), .freg_wb(freg_wb), .freg_idx(freg_idx));

// ### tb/ssx_regfile_model.sv
`timescale 1ns/1ps
module ssx_regfile_model
    import ssx_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic [6:0] freg_idx,
    input  wire ssx_wb_t    freg_wb,
    output ssx_freg_t       freg_in
);
    // read port is combinational, as the alu samples it during the access phase
    logic [7:0] mem [128];
    assign freg_in = '{idx: freg_idx, data: mem[freg_idx]};
    always @(posedge pclk) begin
        if (freg_wb.valid === 1'b1) begin
            mem[freg_wb.idx] <= freg_wb.data;
        end
    end
endmodule

// ### tb/ssx_alu_tb.sv
`timescale 1ns/1ps
module ssx_alu_tb;
    import ssx_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hf;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    ssx_freg_t   freg_in;
    ssx_wb_t     freg_wb;
    logic [6:0]  freg_idx;
    int          mismatches = 0;
    int          check_count = 0;
    logic [6:0]  last_wb_idx = 7'h00;
    logic [7:0]  last_res = 8'h00;
    logic        last_tgt = 1'b0;
    always #5 pclk = ~pclk;
    ssx_alu i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .freg_in(freg_in), .freg_wb(freg_wb), .freg_idx(freg_idx));
    ssx_regfile_model i_rf (.pclk(pclk), .freg_idx(freg_idx), .freg_wb(freg_wb), .freg_in(freg_in));
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    // --------------------------------------------------------
    // apb master: waits for pready, bounded
    // --------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) begin
            mismatches++;
            close_out();
        end
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic run_op(input logic [3:0] op, input logic tgt, input logic [7:0] acc,
                          input logic [7:0] imm, input logic [6:0] idx, input logic [7:0] rv);
        logic [31:0] rd;
        logic        e;
        logic [7:0]  m;
        logic [7:0]  r;
        logic [2:0]  fl;
        logic        wreg;
        m = (op == 4'h1 || op == 4'h4) ? imm : rv;
        r = (op < 4'h3) ? m - acc : (op == 4'h3) ? {m[3:0], m[7:4]} : m ^ acc;
        fl = {r == 8'h00, acc[3:0] <= m[3:0], acc <= m};
        // flags not touched by the op keep the preset taken from rv
        if (op == 4'h3) fl = rv[2:0];
        if (op > 4'h3) fl[1:0] = rv[1:0];
        wreg = tgt && op != 4'h1 && op != 4'h4;
        i_rf.mem[idx] <= rv;
        apb(1'b1, SSX_OFF_ACC, {24'h0, acc}, rd, e);
        apb(1'b1, SSX_OFF_STATUS, {29'h0, rv[2:0]}, rd, e);
        apb(1'b1, SSX_OFF_OPER, {17'h0, idx, imm}, rd, e);
        apb(1'b1, SSX_OFF_CMD, {27'h0, tgt, op}, rd, e);
        chk("cmd error", 32'h0, {31'h0, e});
        last_res = r;
        last_tgt = wreg;
        if (wreg) begin
            last_wb_idx = idx;
        end
        apb(1'b0, SSX_OFF_OPER, 32'h0, rd, e);
        chk("oper", {17'h0, idx, imm}, rd);
        apb(1'b0, SSX_OFF_RESULT, 32'h0, rd, e);
        chk("result", {9'h0, last_wb_idx, 7'h0, last_tgt, last_res}, rd);
        apb(1'b0, SSX_OFF_ACC, 32'h0, rd, e);
        chk("acc", {24'h0, wreg ? acc : r}, rd);
        chk("file reg", {24'h0, wreg ? r : rv}, {24'h0, i_rf.mem[idx]});
        apb(1'b0, SSX_OFF_STATUS, 32'h0, rd, e);
        chk("status", {29'h0, fl}, rd);
    endtask
    task automatic sc_sub_imm;
        run_op(4'h1, 1'b1, 8'h05, 8'h03, 7'h01, 8'h00);
        run_op(4'h1, 1'b0, 8'h18, 8'h21, 7'h02, 8'h07);
        run_op(4'h1, 1'b0, 8'h37, 8'h37, 7'h03, 8'h00);
        run_op(4'h1, 1'b0, 8'h00, 8'hff, 7'h04, 8'h02);
    endtask
    task automatic sc_sub_reg;
        run_op(4'h2, 1'b0, 8'h03, 8'h00, 7'h00, 8'h5c);
        run_op(4'h2, 1'b1, 8'h9f, 8'h00, 7'h7f, 8'h91);
        run_op(4'h2, 1'b1, 8'h44, 8'h00, 7'h40, 8'h44);
    endtask
    task automatic sc_swap;
        run_op(4'h3, 1'b0, 8'h11, 8'h00, 7'h10, 8'ha5);
        run_op(4'h3, 1'b1, 8'h22, 8'h00, 7'h7f, 8'h3e);
    endtask
    task automatic sc_xor;
        run_op(4'h4, 1'b1, 8'h6c, 8'h6c, 7'h05, 8'h03);
        run_op(4'h4, 1'b0, 8'hf0, 8'h0f, 7'h06, 8'h04);
        run_op(4'h5, 1'b0, 8'h81, 8'h00, 7'h20, 8'h81);
        run_op(4'h5, 1'b1, 8'h5a, 8'h00, 7'h21, 8'hc6);
    endtask
    task automatic sc_refuse;
        logic [31:0] rd;
        logic        e;
        logic [3:0]  bad [3] = '{4'h0, 4'h6, 4'hf};
        apb(1'b1, SSX_OFF_ACC, 32'h0000_0042, rd, e);
        apb(1'b1, SSX_OFF_OPER, 32'h0000_00ff, rd, e);
        // lane 0 strobe off: the xor command must be ignored
        pstrb <= 4'he;
        apb(1'b1, SSX_OFF_CMD, 32'h0000_0004, rd, e);
        chk("masked cmd error", 32'h0, {31'h0, e});
        pstrb <= 4'hf;
        foreach (bad[i]) begin
            apb(1'b1, SSX_OFF_CMD, {27'h0, 1'b1, bad[i]}, rd, e);
            chk("bad op error", 32'h1, {31'h0, e});
        end
        apb(1'b1, SSX_OFF_CMD, 32'h0000_0007, rd, e);
        chk("bad op error", 32'h1, {31'h0, e});
        apb(1'b1, SSX_OFF_RESULT, 32'hffff_ffff, rd, e);
        chk("result write error", 32'h0, {31'h0, e});
        apb(1'b0, SSX_OFF_RESULT, 32'h0, rd, e);
        chk("result kept", {9'h0, last_wb_idx, 7'h0, last_tgt, last_res}, rd);
        apb(1'b0, 12'h014, 32'h0, rd, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        apb(1'b0, SSX_OFF_ACC, 32'h0, rd, e);
        chk("acc kept", 32'h0000_0042, rd);
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        sc_sub_imm();
        sc_sub_reg();
        sc_swap();
        sc_xor();
        sc_refuse();
        close_out();
    end
endmodule
